//--- hdl/bit_sync.sv
`timescale 1ns/1ps
`default_nettype none
module bit_sync #(
	parameter int unsigned WIDTH = 1
) (
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire logic [WIDTH-1:0] d,
	output var  logic [WIDTH-1:0] q
);
	logic [WIDTH-1:0] meta_r;
	logic [WIDTH-1:0] meta_nxt;
	logic [WIDTH-1:0] q_nxt;

	// first stage feeds the second stage only
	always_comb begin
		meta_nxt = rst ? '0 : d;
		q_nxt    = rst ? '0 : meta_r;
	end

	always_ff @(posedge clk) begin
		meta_r <= meta_nxt;
		q      <= q_nxt;
	end
endmodule // bit_sync
`default_nettype wire

//--- hdl/config_loader.sv
`timescale 1ns/1ps
`default_nettype none
module config_loader (
	input  wire logic                 ref_clk,
	input  wire logic                 srst,
	input  wire logic                 hub_clk,
	input  wire logic                 hsel,
	input  wire logic [31:0]          haddr,
	input  wire logic [1:0]           htrans,
	input  wire logic                 hwrite,
	input  wire logic [2:0]           hsize,
	input  wire logic [31:0]          hwdata,
	input  wire logic                 hready,
	output logic                      hreadyout,
	output logic                      hresp,
	output logic [31:0]               hrdata,
	input  wire logic                 external_config_memory_select,
	input  wire logic                 scl_in,
	output logic                      scl_out,
	output logic                      scl_oe,
	input  wire logic                 sda_in,
	output logic                      sda_out,
	output logic                      sda_oe,
	output logic                      scl_pd_en,
	output logic                      sda_pd_en,
	output loader_pkg::config_t       cfg,
	output loader_pkg::power_mode_t   power_mode,
	output logic                      config_valid
);
	// ---------------- hub clock side ----------------
	logic [3:0]               l_sync;
	logic                     l_rst;
	logic                     l_select;
	logic                     l_sda;
	logic                     l_suspend;
	logic                     suspend_r;

	loader_pkg::load_state_t  state_r;
	loader_pkg::load_state_t  state_nxt;
	logic [2:0]               half_r;
	logic [2:0]               half_nxt;
	logic [5:0]               cnt_r;
	logic [5:0]               cnt_nxt;
	logic [7:0]               cmd_r;
	logic [7:0]               cmd_nxt;
	logic [47:0]              shift_r;
	logic [47:0]              shift_nxt;
	logic                     scl_r;
	logic                     scl_nxt;
	logic                     scl_oe_r;
	logic                     scl_oe_nxt;
	logic                     sda_r;
	logic                     sda_nxt;
	logic                     sda_oe_r;
	logic                     sda_oe_nxt;
	logic                     pd_en_r;
	logic                     pd_en_nxt;
	logic                     done_r;
	logic                     done_nxt;
	logic                     dummy_bad_r;
	logic                     dummy_bad_nxt;

	// reset, strap, data pin and suspend request all cross into hub clock
	bit_sync #(
		.WIDTH (4)
	) u_link_sync (
		.clk (hub_clk),
		.rst (1'b0),
		.d   ({srst, external_config_memory_select, sda_in, suspend_r}),
		.q   (l_sync)
	);

	always_comb begin
		l_rst     = l_sync[3];
		l_select  = l_sync[2];
		l_sda     = l_sync[1];
		l_suspend = l_sync[0];
	end

	// chip select is left to the power-on reset net
	always_comb begin
		state_nxt     = state_r;
		half_nxt      = half_r + 3'h1;
		cnt_nxt       = cnt_r;
		cmd_nxt       = cmd_r;
		shift_nxt     = shift_r;
		scl_nxt       = scl_r;
		scl_oe_nxt    = scl_oe_r;
		sda_nxt       = sda_r;
		sda_oe_nxt    = sda_oe_r;
		done_nxt      = done_r;
		dummy_bad_nxt = dummy_bad_r;
		pd_en_nxt     = l_select & ~l_suspend;
		unique case (state_r)
			loader_pkg::LD_SETTLE: begin
				// let the strap pass its synchroniser before deciding
				if (half_r == loader_pkg::SETTLE_LAST) begin
					half_nxt = '0;
					cnt_nxt  = '0;
					if (l_select) begin
						state_nxt  = loader_pkg::LD_SEND;
						cmd_nxt    = {loader_pkg::CMD_WORD[6:0], 1'b0};
						sda_nxt    = loader_pkg::CMD_WORD[7];
						sda_oe_nxt = 1'b1;
						scl_nxt    = 1'b0;
						scl_oe_nxt = 1'b1;
					end else begin
						state_nxt = loader_pkg::LD_OFF;
					end
				end
			end
			loader_pkg::LD_SEND: begin
				if (half_r == loader_pkg::HALF_LAST) begin
					half_nxt = '0;
					if (!scl_r) begin
						scl_nxt = 1'b1;
					end else begin
						scl_nxt = 1'b0;
						if (cnt_r == loader_pkg::CMD_LAST) begin
							// memory owns the wire from here
							sda_oe_nxt = 1'b0;
							sda_nxt    = 1'b0;
							cnt_nxt    = '0;
							state_nxt  = loader_pkg::LD_RECV;
						end else begin
							cnt_nxt = cnt_r + 6'h01;
							sda_nxt = cmd_r[7];
							cmd_nxt = {cmd_r[6:0], 1'b0};
						end
					end
				end
			end
			loader_pkg::LD_RECV: begin
				if (half_r == loader_pkg::HALF_LAST) begin
					half_nxt = '0;
					if (!scl_r) begin
						// dummy bit stands in the first low phase
						if (cnt_r == '0) begin
							dummy_bad_nxt = l_sda;
						end
						scl_nxt = 1'b1;
					end else begin
						// sample late in the high phase: data moved at the
						// rising edge and the synchroniser needs two cycles
						shift_nxt = {shift_r[46:0], l_sda};
						scl_nxt   = 1'b0;
						if (cnt_r == loader_pkg::DATA_LAST) begin
							// three words streamed without readdressing
							scl_oe_nxt = 1'b0;
							done_nxt   = 1'b1;
							state_nxt  = loader_pkg::LD_DONE;
						end else begin
							cnt_nxt = cnt_r + 6'h01;
						end
					end
				end
			end
			loader_pkg::LD_DONE: begin
				// one read per reset; stays parked
				half_nxt = '0;
			end
			loader_pkg::LD_OFF: begin
				half_nxt = '0;
			end
			default: begin
				state_nxt = loader_pkg::LD_SETTLE;
				half_nxt  = '0;
			end
		endcase
		if (l_rst) begin
			state_nxt     = loader_pkg::LD_SETTLE;
			half_nxt      = '0;
			cnt_nxt       = '0;
			cmd_nxt       = '0;
			shift_nxt     = '0;
			scl_nxt       = 1'b0;
			scl_oe_nxt    = 1'b0;
			sda_nxt       = 1'b0;
			sda_oe_nxt    = 1'b0;
			pd_en_nxt     = 1'b0;
			done_nxt      = 1'b0;
			dummy_bad_nxt = 1'b0;
		end
	end

	// all of this runs on the hub clock
	always_ff @(posedge hub_clk) begin
		state_r     <= state_nxt;
		half_r      <= half_nxt;
		cnt_r       <= cnt_nxt;
		cmd_r       <= cmd_nxt;
		shift_r     <= shift_nxt;
		scl_r       <= scl_nxt;
		scl_oe_r    <= scl_oe_nxt;
		sda_r       <= sda_nxt;
		sda_oe_r    <= sda_oe_nxt;
		pd_en_r     <= pd_en_nxt;
		done_r      <= done_nxt;
		dummy_bad_r <= dummy_bad_nxt;
	end

	always_comb begin
		scl_out   = scl_r;
		scl_oe    = scl_oe_r;
		sda_out   = sda_r;
		sda_oe    = sda_oe_r;
		scl_pd_en = pd_en_r;
		sda_pd_en = pd_en_r;
	end

	// ---------------- register clock side ----------------
	logic [4:0]               r_sync;
	logic                     r_done;
	logic                     r_dummy_bad;
	logic                     r_select;
	logic                     r_pin_bus;
	logic                     r_pin_gang;
	logic                     done_d_r;
	logic                     done_d_nxt;
	loader_pkg::config_t      cfg_r;
	loader_pkg::config_t      cfg_nxt;
	loader_pkg::power_mode_t  mode_r;
	loader_pkg::power_mode_t  mode_nxt;
	logic                     valid_r;
	logic                     valid_nxt;
	logic                     suspend_nxt;
	logic                     wr_pend_r;
	logic                     wr_pend_nxt;
	logic [11:0]              wr_addr_r;
	logic [11:0]              wr_addr_nxt;
	logic [31:0]              rdata_r;
	logic [31:0]              rdata_nxt;
	logic                     take;
	logic [11:0]              a_ofs;

	// no reset here: a reset sync would show select low just after release
	bit_sync #(
		.WIDTH (5)
	) u_reg_sync (
		.clk (ref_clk),
		.rst (1'b0),
		.d   ({done_r, dummy_bad_r, external_config_memory_select,
		       scl_in, sda_in}),
		.q   (r_sync)
	);

	always_comb begin
		r_done      = r_sync[4];
		r_dummy_bad = r_sync[3];
		r_select    = r_sync[2];
		r_pin_bus   = r_sync[1];
		r_pin_gang  = r_sync[0];
	end

	// configuration storage
	always_comb begin
		done_d_nxt = r_done;
		cfg_nxt    = cfg_r;
		valid_nxt  = valid_r;
		if (!r_select) begin
			// interface off: the two pins are plain strap inputs
			cfg_nxt.vendor_id  = loader_pkg::DEFAULT_VENDOR_ID;
			cfg_nxt.product_id = loader_pkg::DEFAULT_PRODUCT_ID;
			cfg_nxt.bus_power  = r_pin_bus;
			cfg_nxt.gang       = r_pin_gang;
			valid_nxt          = 1'b1;
		end else if (r_done && !done_d_r) begin
			// shift_r is frozen once done is seen, safe to read here
			cfg_nxt.vendor_id  = shift_r[47:32];
			cfg_nxt.product_id = shift_r[31:16];
			cfg_nxt.bus_power  = shift_r[loader_pkg::PWR_BUS_BIT];
			cfg_nxt.gang       = shift_r[loader_pkg::PWR_GANG_BIT];
			valid_nxt          = 1'b1;
		end
		mode_nxt = loader_pkg::power_mode_t'({cfg_r.bus_power,
		                                      cfg_r.gang});
		if (srst) begin
			done_d_nxt = 1'b0;
			cfg_nxt    = '0;
			valid_nxt  = 1'b0;
			mode_nxt   = loader_pkg::PM_SELF_INDIV;
		end
	end

	// bus slave: zero wait, read data registered in the address phase
	always_comb begin
		take        = hsel & htrans[loader_pkg::HTRANS_ACT] & hready;
		a_ofs       = {haddr[11:2], 2'b00};
		wr_pend_nxt = take & hwrite;
		wr_addr_nxt = a_ofs;
		suspend_nxt = suspend_r;
		if (wr_pend_r && wr_addr_r == loader_pkg::OFS_CONTROL) begin
			suspend_nxt = hwdata[loader_pkg::CTRL_SUSP_BIT];
		end
		rdata_nxt = rdata_r;
		if (take && !hwrite) begin
			rdata_nxt = '0;
			if (haddr[31:12] == '0) begin
				unique case (a_ofs)
					loader_pkg::OFS_VENDOR:
						rdata_nxt[15:0] = cfg_r.vendor_id;
					loader_pkg::OFS_PRODUCT:
						rdata_nxt[15:0] = cfg_r.product_id;
					loader_pkg::OFS_POWER: begin
						rdata_nxt[loader_pkg::PWR_BUS_BIT]  = cfg_r.bus_power;
						rdata_nxt[loader_pkg::PWR_GANG_BIT] = cfg_r.gang;
					end
					loader_pkg::OFS_STATUS: begin
						rdata_nxt[loader_pkg::ST_DONE_BIT]  = valid_r;
						rdata_nxt[loader_pkg::ST_SEL_BIT]   = r_select;
						rdata_nxt[loader_pkg::ST_SUSP_BIT]  = suspend_r;
						rdata_nxt[loader_pkg::ST_DUMMY_BIT] = r_dummy_bad
						                                      & r_done;
					end
					loader_pkg::OFS_CONTROL:
						// newest value wins on a write then read
						rdata_nxt[loader_pkg::CTRL_SUSP_BIT] = suspend_nxt;
					default:
						rdata_nxt = '0;
				endcase
			end
		end
		if (srst) begin
			wr_pend_nxt = 1'b0;
			wr_addr_nxt = '0;
			suspend_nxt = 1'b0;
			rdata_nxt   = '0;
		end
	end

	always_ff @(posedge ref_clk) begin
		done_d_r  <= done_d_nxt;
		cfg_r     <= cfg_nxt;
		mode_r    <= mode_nxt;
		valid_r   <= valid_nxt;
		wr_pend_r <= wr_pend_nxt;
		wr_addr_r <= wr_addr_nxt;
		suspend_r <= suspend_nxt;
		rdata_r   <= rdata_nxt;
	end

	// hready and hresp never change: every transfer is zero wait, OKAY
	logic hready_r;
	logic hready_nxt;

	always_comb begin
		hready_nxt = 1'b1;
	end

	always_ff @(posedge ref_clk) begin
		hready_r <= hready_nxt;
	end

	always_comb begin
		hreadyout    = hready_r;
		hresp        = 1'b0;
		hrdata       = rdata_r;
		cfg          = cfg_r;
		power_mode   = mode_r;
		config_valid = valid_r;
	end
endmodule // config_loader
`default_nettype wire

//--- hdl/loader_pkg.sv
package loader_pkg;
	localparam logic [7:0]  CMD_WORD    = 8'hC0;
	localparam int unsigned CMD_BITS    = 8;
	localparam int unsigned WORD_BITS   = 16;
	localparam int unsigned WORD_COUNT  = 3;
	localparam int unsigned DATA_BITS   = WORD_BITS * WORD_COUNT;
	localparam int unsigned CNT_W       = 6;
	localparam logic [5:0]  CMD_LAST    = 6'h07;
	localparam logic [5:0]  DATA_LAST   = 6'h2F;
	localparam int unsigned HALF_W      = 3;
	localparam logic [2:0]  HALF_LAST   = 3'h3;
	localparam logic [2:0]  SETTLE_LAST = 3'h7;

	localparam int unsigned ADDR_W      = 12;
	localparam logic [11:0] OFS_VENDOR  = 12'h000;
	localparam logic [11:0] OFS_PRODUCT = 12'h004;
	localparam logic [11:0] OFS_POWER   = 12'h008;
	localparam logic [11:0] OFS_STATUS  = 12'h00C;
	localparam logic [11:0] OFS_CONTROL = 12'h010;
	localparam int unsigned HTRANS_ACT  = 1;

	localparam int unsigned PWR_BUS_BIT  = 0;
	localparam int unsigned PWR_GANG_BIT = 1;
	localparam int unsigned ST_DONE_BIT  = 0;
	localparam int unsigned ST_SEL_BIT   = 1;
	localparam int unsigned ST_SUSP_BIT  = 2;
	localparam int unsigned ST_DUMMY_BIT = 3;
	localparam int unsigned CTRL_SUSP_BIT = 0;

	// arbitrary neutral identifiers used when no memory is fitted
	localparam logic [15:0] DEFAULT_VENDOR_ID  = 16'h0001;
	localparam logic [15:0] DEFAULT_PRODUCT_ID = 16'h0001;

	typedef enum logic [2:0] {
		LD_SETTLE = 3'b000,
		LD_SEND   = 3'b001,
		LD_RECV   = 3'b010,
		LD_DONE   = 3'b011,
		LD_OFF    = 3'b100
	} load_state_t;

	typedef enum logic [1:0] {
		PM_SELF_INDIV = 2'b00,
		PM_SELF_GANG  = 2'b01,
		PM_BUS_INDIV  = 2'b10,
		PM_BUS_GANG   = 2'b11
	} power_mode_t;

	typedef struct packed {
		logic [15:0] vendor_id;
		logic [15:0] product_id;
		logic        bus_power;
		logic        gang;
	} config_t;
endpackage

//--- verification/hub_serial_eeprom_config_loader_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module hub_serial_eeprom_config_loader_tb_top;
	logic        ref_clk = 1'b0;
	logic        hub_clk = 1'b0;
	logic        srst = 1'b1;
	logic        hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0]  htrans = 2'h0;
	logic        hwrite = 1'b0;
	logic [2:0]  hsize = 3'h0;
	logic [31:0] hwdata = 32'h0;
	logic        sel = 1'b0;
	logic [1:0]  strap = 2'h0;
	logic        dummy_one = 1'b0;
	logic [47:0] words = 48'h0;
	logic        hreadyout, hresp, scl_out, scl_oe, sda_out, sda_oe;
	logic        scl_pd_en, sda_pd_en, config_valid, mem_q, mem_oe;
	logic        scl_w, sda_w;
	logic [31:0] hrdata;
	logic [7:0]  cmd_seen;
	logic [15:0] exp_q[$];
	int          n_mismatch = 0, check_count = 0, cycles = 0, seed = 25252;
	loader_pkg::config_t     cfg;
	loader_pkg::power_mode_t power_mode;
	// device wins over the memory through the series resistor
	// undriven pins pulled low, or straps when select low
	assign scl_w = scl_oe ? scl_out : (sel ? 1'b0 : strap[1]);
	assign sda_w = sda_oe ? sda_out : mem_oe ? mem_q : (sel ? 1'b0 : strap[0]);
	always #2 ref_clk = ~ref_clk;
	initial #1.3 forever #80 hub_clk = ~hub_clk;
	config_loader dut (.ref_clk, .srst, .hub_clk, .hsel, .haddr, .htrans,
		.hwrite, .hsize, .hwdata, .hready(hreadyout), .hreadyout,
		.hresp, .hrdata, .external_config_memory_select(sel),
		.scl_in(scl_w), .scl_out, .scl_oe, .sda_in(sda_w), .sda_out,
		.sda_oe, .scl_pd_en, .sda_pd_en, .cfg, .power_mode, .config_valid);
	// chip select follows reset
	serial_mem_model mem (.scl(scl_w), .sda(sda_w), .cs(!srst), .dummy_one,
		.words, .q(mem_q), .q_oe(mem_oe), .cmd_seen);
	task automatic check(input string what, input logic [47:0] seen, exp);
		check_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("unexpected %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic ahb(input logic wr, input logic [11:0] a,
			input logic [31:0] wd, output logic [31:0] rd);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= {20'h0, a};
		hwrite <= wr;
		hsize <= 3'h2;
		do @(posedge ref_clk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= wd;
		do @(posedge ref_clk); while (hreadyout !== 1'b1);
		rd = hrdata;
		check("response", hresp, 1'b0);
	endtask
	// bounded poll: the suspend request crosses into the link domain
	task automatic wait_pd(input logic v);
		for (int k = 0; k < 400 && scl_pd_en !== v; k++)
			@(posedge ref_clk);
	endtask
	task automatic load(input int i);
		logic [31:0] rd;
		logic [47:0] w;
		logic [1:0]  m;
		w = 48'({$random(seed), $random(seed)});
		m = 2'(i);
		w[1:0] = {m[0], m[1]};
		exp_q.delete();
		exp_q.push_back(i < 3 ? w[47:32] : loader_pkg::DEFAULT_VENDOR_ID);
		exp_q.push_back(i < 3 ? w[31:16] : loader_pkg::DEFAULT_PRODUCT_ID);
		@(posedge ref_clk);
		srst <= 1'b1;
		sel <= (i < 3);
		strap <= m;
		words <= w;
		dummy_one <= (i == 1);
		repeat (200) @(posedge ref_clk);
		srst <= 1'b0;
		while (config_valid !== 1'b1) @(posedge ref_clk);
		repeat (4) @(posedge ref_clk);
		check("vendor", cfg.vendor_id, exp_q[0]);
		check("product", cfg.product_id, exp_q[1]);
		check("mode", power_mode, m);
		check("command", cmd_seen, i < 3 ? {1'b1, 2'b10, 5'b0} : 8'h0);
		check("released", {scl_oe, sda_oe}, 2'b00);
		check("pulldown", {scl_pd_en, sda_pd_en}, {2{sel}});
		ahb(1'b1, loader_pkg::OFS_VENDOR, $random(seed), rd);
		ahb(1'b0, loader_pkg::OFS_VENDOR, 32'h0, rd);
		check("vendor reg", rd, {16'h0, exp_q[0]});
		ahb(1'b0, loader_pkg::OFS_PRODUCT, 32'h0, rd);
		check("product reg", rd, {16'h0, exp_q[1]});
		ahb(1'b0, loader_pkg::OFS_POWER, 32'h0, rd);
		check("power reg", rd, {30'h0, m[0], m[1]});
		ahb(1'b0, loader_pkg::OFS_STATUS, 32'h0, rd);
		check("status", rd, {28'h0, dummy_one, 1'b0, sel, 1'b1});
		ahb(1'b0, 12'h014, 32'h0, rd);
		check("unmapped", rd, 32'h0);
		ahb(1'b1, loader_pkg::OFS_CONTROL, 32'h1, rd);
		wait_pd(1'b0);
		check("suspend pulldown", {scl_pd_en, sda_pd_en}, 2'b00);
		ahb(1'b0, loader_pkg::OFS_CONTROL, 32'h0, rd);
		check("control", rd, 32'h1);
		ahb(1'b1, loader_pkg::OFS_CONTROL, 32'h0, rd);
		wait_pd(sel);
		check("wake pulldown", {scl_pd_en, sda_pd_en}, {2{sel}});
		$display("load %0d done", i);
	endtask
	task automatic stop_test;
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// six loads, three of them from the memory at about 19k cycles each, set the ceiling
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 80000) begin
			n_mismatch++;
			stop_test();
		end
	end
	initial begin
		for (int i = 0; i < 6; i++)
			load(i);
		stop_test();
	end
endmodule // hub_serial_eeprom_config_loader_tb_top
`default_nettype wire

//--- verification/loader_checker_properties.sv
`timescale 1ns/1ps
`default_nettype none
module loader_checker (
	input wire logic                    ref_clk,
	input wire logic                    srst,
	input wire logic                    hub_clk,
	input wire logic                    external_config_memory_select,
	input wire logic                    scl_out,
	input wire logic                    scl_oe,
	input wire logic                    sda_out,
	input wire logic                    sda_oe,
	input wire logic                    scl_pd_en,
	input wire logic                    sda_pd_en,
	input wire loader_pkg::config_t     cfg,
	input wire loader_pkg::power_mode_t power_mode,
	input wire logic                    config_valid
);
	logic [1:0] starts_r;
	logic [1:0] starts_nxt;
	logic       oe_d_r;
	// saturating count of read sequences begun since reset
	always_comb begin
		starts_nxt = starts_r;
		if (sda_oe && !oe_d_r && starts_r != 2'h3)
			starts_nxt = starts_r + 2'h1;
	end
	always_ff @(posedge hub_clk) begin
		if (srst) begin
			starts_r <= 2'h0;
			oe_d_r <= 1'b0;
		end else begin
			starts_r <= starts_nxt;
			oe_d_r <= sda_oe;
		end
	end
	one_read_a:
	assert property (@(posedge hub_clk) disable iff (srst) starts_r < 2'h2)
		else $error("more than one read sequence");
	cmd_bits_a:
	assert property (@(posedge hub_clk) disable iff (srst) $rose(sda_oe) |->
		(sda_out && !scl_out)[*4] ##1 sda_out[*4] ##1 sda_out[*8]
		##1 (!sda_out && sda_oe)[*8]) else $error("bad command bits");
	data_release_a:
	assert property (@(posedge hub_clk) disable iff (srst) $rose(sda_oe) |->
		##63 sda_oe ##1 (!sda_oe && !scl_out)) else $error("bad release");
	scl_half_a:
	assert property (@(posedge hub_clk) disable iff (srst)
		$rose(scl_out) |-> scl_out[*4] ##1 !scl_out)
		else $error("serial clock high phase wrong");
	pd_pair_a:
	assert property (@(posedge hub_clk) disable iff (srst)
		scl_pd_en == sda_pd_en) else $error("pulldowns differ");
	sel_low_pd_a:
	assert property (@(posedge hub_clk) disable iff (srst)
		(!external_config_memory_select)[*6] |-> !scl_pd_en)
		else $error("pulldown on with select low");
	sel_low_idle_a:
	assert property (@(posedge hub_clk) disable iff (srst)
		(!external_config_memory_select)[*6] |-> !sda_oe && !scl_oe)
		else $error("pins driven with select low");
	end_float_a:
	assert property (@(posedge hub_clk) disable iff (srst)
		$fell(scl_oe) |-> (!sda_oe && !scl_oe)[*8])
		else $error("pins driven after load");
	mode_map_a:
	assert property (@(posedge ref_clk) disable iff (srst) !$past(srst) |->
		power_mode == {$past(cfg.bus_power), $past(cfg.gang)})
		else $error("power mode not from settings");
	cfg_hold_a:
	assert property (@(posedge ref_clk) disable iff (srst)
		config_valid[*4] |=> config_valid && $stable(cfg))
		else $error("configuration changed after load");
	cover property (@(posedge hub_clk) disable iff (srst) $fell(scl_oe));
	cover property (@(posedge ref_clk) disable iff (srst) $rose(config_valid));
	cover property (@(posedge hub_clk) disable iff (srst)
		external_config_memory_select && !scl_pd_en);
endmodule // loader_checker
bind config_loader loader_checker chk (.ref_clk, .srst, .hub_clk,
	.external_config_memory_select, .scl_out, .scl_oe, .sda_out, .sda_oe,
	.scl_pd_en, .sda_pd_en, .cfg, .power_mode, .config_valid);
`default_nettype wire

//--- verification/serial_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module serial_mem_model (
	input  wire logic        scl,
	input  wire logic        sda,
	input  wire logic        cs,
	input  wire logic        dummy_one,
	input  wire logic [47:0] words,
	output logic             q,
	output logic             q_oe,
	output logic [7:0]       cmd_seen
);
	int rises = 0;
	// 32x16 organisation, three words from address zero
	always @(posedge scl or negedge cs) begin
		if (!cs) begin
			rises = 0;
			q_oe <= 1'b0;
			q <= 1'b0;
			cmd_seen <= 8'h00;
		end else if (rises > 0 || sda) begin
			rises = rises + 1;
			if (rises <= 8)
				cmd_seen <= {cmd_seen[6:0], sda};
			if (rises == 8) begin
				q_oe <= 1'b1;
				q <= dummy_one;
			end else if (rises > 8 && rises <= 56)
				q <= words[56-rises];
		end
	end
	// hold time over once the last bit has been clocked out
	always @(negedge scl) begin
		if (rises >= 56)
			q_oe <= 1'b0;
	end
endmodule // serial_mem_model
`default_nettype wire
